// [fpsi_blink_gen.sv]
`timescale 1ns/1ns
module fpsi_blink_gen #(
  parameter int CYC_PER_MS = fpsi_pkg::CYC_PER_MS
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      ms_tick_out,
  output logic      slow_out,
  output logic      fast_out,
  output logic      link_out,
  output logic      uv_out,
  output logic      flick_out,
  output logic      flash_out,
  output logic      imp_out
);
  localparam int DW = $clog2(CYC_PER_MS);
  if (CYC_PER_MS < 2) $error("divider needs at least two cycles per ms");

  typedef struct packed {
    logic [DW-1:0] div;
    logic [12:0]   ms;
    logic          tick;
    logic          slow, fast, link, uv, flick, flash, imp;
  } fpsi_bg_t;

  fpsi_bg_t s_ff, nxt_s;

  function automatic logic half(input logic [12:0] t, input int h);
    half = (int'(t) % (2 * h)) < h;
  endfunction

  // one divider feeds every pattern so equal rates stay aligned
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (int'(s_ff.div) == CYC_PER_MS - 1) begin
      nxt_s.div  = '0;
      nxt_s.tick = 1'b1;
      nxt_s.ms   = (int'(s_ff.ms) == fpsi_pkg::WRAP_MS - 1) ? 13'h0000 : s_ff.ms + 13'h0001;
    end else begin
      nxt_s.div = s_ff.div + DW'(1);
    end
    nxt_s.slow  = half(s_ff.ms, fpsi_pkg::SLOW_HALF_MS);
    nxt_s.fast  = half(s_ff.ms, fpsi_pkg::FAST_HALF_MS);
    nxt_s.link  = half(s_ff.ms, fpsi_pkg::LINK_HALF_MS);
    nxt_s.uv    = half(s_ff.ms, fpsi_pkg::UV_HALF_MS);
    nxt_s.flick = half(s_ff.ms, fpsi_pkg::FLICK_HALF_MS);
    nxt_s.flash = (int'(s_ff.ms) % fpsi_pkg::FLASH_PER_MS) < fpsi_pkg::FLASH_ON_MS;
    nxt_s.imp   = (int'(s_ff.ms) % fpsi_pkg::IMP_PER_MS) < fpsi_pkg::IMP_ON_MS;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ms_tick_out = s_ff.tick;
  assign slow_out    = s_ff.slow;
  assign fast_out    = s_ff.fast;
  assign link_out    = s_ff.link;
  assign uv_out      = s_ff.uv;
  assign flick_out   = s_ff.flick;
  assign flash_out   = s_ff.flash;
  assign imp_out     = s_ff.imp;
endmodule

// [fpsi_chk_asserts.sv]
`timescale 1ns/1ns
module fpsi_chk #(
  parameter int CYC_PER_MS   = 4,
  parameter int CAL_BLOCK_MS = 20
) (
  // clock and reset
  input wire logic        MCLK_IN,
  input wire logic        RST_IN,
  // byte bus and core status
  input wire logic        RD_STB_IN,
  input wire logic [7:0]  RD_DATA_OUT,
  input wire logic        CAL_DONE_OK_IN,
  input wire logic        CAL_DONE_BAD_IN,
  input wire logic [11:0] ACTUAL_CODE_IN,
  input wire logic        RANGE_500_IN,
  input wire logic        LINK_ACTIVE_IN,
  input wire logic [1:0]  LINK_STATE_IN,
  // lamps and flags
  input wire logic        LED_CAL_OUT,
  input wire logic        LED_HEAT_OUT,
  input wire logic        LED_RUN_OUT,
  input wire logic        LED_ERR_OUT,
  input wire logic        CAL_ACTIVE_OUT,
  input wire logic        CAL_BLOCKED_OUT,
  input wire logic        ALARM_ACTIVE_OUT,
  input wire logic        REG_ACTIVE_OUT,
  input wire logic [11:0] ACTUAL_DAC_OUT
);
  int unsigned cnt_ff;
  // cycles since reset release, saturating
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) cnt_ff <= 0;
    else if (cnt_ff < 100000) cnt_ff <= cnt_ff + 1;
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  boot_lamp_a: assert property (cnt_ff >= 3 && cnt_ff <= 8 |-> LED_CAL_OUT)
    else $error("boot lamp dark");
  block_win_a: assert property (cnt_ff >= 4 && cnt_ff <= CAL_BLOCK_MS * CYC_PER_MS - 10
    |-> CAL_BLOCKED_OUT && !CAL_ACTIVE_OUT) else $error("calibration not blocked");
  cal_hold_a: assert property (CAL_ACTIVE_OUT |-> LED_CAL_OUT && ACTUAL_DAC_OUT == 12'h000)
    else $error("calibration lamp or output wrong");
  fail_flag_a: assert property (CAL_DONE_BAD_IN && CAL_ACTIVE_OUT |-> ##2 ALARM_ACTIVE_OUT && !CAL_ACTIVE_OUT)
    else $error("failed calibration not flagged");
  ok_zero_a: assert property (CAL_DONE_OK_IN && CAL_ACTIVE_OUT |-> ##2 !CAL_ACTIVE_OUT && !LED_CAL_OUT
    && ACTUAL_DAC_OUT == (RANGE_500_IN ? fpsi_pkg::DAC_ZP500 : fpsi_pkg::DAC_ZP300) + ACTUAL_CODE_IN)
    else $error("zero point output wrong");
  reg_heat_a: assert property (REG_ACTIVE_OUT |-> LED_HEAT_OUT && !CAL_ACTIVE_OUT)
    else $error("regulation without heat lamp");
  link_dark_a: assert property (!LINK_ACTIVE_IN [*3] |-> !LED_RUN_OUT && !LED_ERR_OUT)
    else $error("link lamps lit without link");
  run_init_a: assert property (LINK_STATE_IN == fpsi_pkg::LNK_INIT [*3] |-> !LED_RUN_OUT)
    else $error("run lamp lit in init");
  rd_hold_a: assert property (!$past(RD_STB_IN) |-> $stable(RD_DATA_OUT))
    else $error("read byte changed without strobe");
endmodule
bind fpsi_top fpsi_chk #(.CYC_PER_MS(CYC_PER_MS), .CAL_BLOCK_MS(CAL_BLOCK_MS)) u_chk (.*);

// [fpsi_master.sv]
`timescale 1ns/1ns
module fpsi_master (
  // clock
  input  wire logic       clk_in,
  // byte stream to the block
  output logic            xfer_out,
  output logic            wr_stb_out,
  output logic      [7:0] wr_data_out,
  output logic            rd_stb_out,
  input  wire logic [7:0] rd_data_in
);
  // only zero words before the first cycle
  initial begin
    xfer_out = 1'b0;
    wr_stb_out = 1'b0;
    wr_data_out = 8'h00;
    rd_stb_out = 1'b0;
  end
  // start then set point and control, low byte first
  task automatic send(input logic [15:0] sp, input logic [15:0] ctl);
    logic [31:0] w;
    w = {ctl, sp};
    @(negedge clk_in) xfer_out = 1'b1;
    @(negedge clk_in) xfer_out = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr_stb_out = 1'b1;
      wr_data_out = w[8*i+:8];
      @(negedge clk_in);
    end
    wr_stb_out = 1'b0;
    wr_data_out = ~wr_data_out; // no stale byte on a released bus
  endtask
  // start then six read bytes, low byte first
  task automatic fetch(output logic [15:0] act, output logic [15:0] sts);
    logic [47:0] r;
    @(negedge clk_in) xfer_out = 1'b1;
    @(negedge clk_in) xfer_out = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_stb_out = 1'b1;
      @(negedge clk_in) r[8*i+:8] = rd_data_in;
    end
    rd_stb_out = 1'b0;
    act = r[15:0];
    sts = r[31:16];
  endtask
endmodule

// [fpsi_pkg.sv]
package fpsi_pkg;
  // clock and derived cycle counts
  localparam int CLK_HZ     = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // power-on indication and blocking windows
  localparam real BOOT_CAL_S   = 0.3;
  localparam int  BOOT_CAL_MS  = int'(BOOT_CAL_S * 1000.0);
  localparam real BOOT_ALM_S   = 1.0;
  localparam int  BOOT_ALM_MS  = int'(BOOT_ALM_S * 1000.0);
  localparam real CAL_BLOCK_S  = 10.0;
  localparam int  CAL_BLOCK_MS = int'(CAL_BLOCK_S * 1000.0);
  localparam int  CFG_CAP_MS   = 1;

  // blink half periods and flash timing in ms
  localparam int SLOW_HALF_MS  = 500;
  localparam int FAST_HALF_MS  = 125;
  localparam int LINK_HALF_MS  = 200;
  localparam int UV_HALF_MS    = 250;
  localparam int FLICK_HALF_MS = 25;
  localparam int FLASH_ON_MS   = 200;
  localparam int FLASH_PER_MS  = 1200;
  localparam real IMP_PER_S    = 1.2;
  localparam int IMP_PER_MS    = int'(IMP_PER_S * 1000.0);
  localparam int IMP_ON_MS     = 20;
  localparam int WRAP_MS       = 6000;
  localparam int ACT_HOLD_MS   = 50;

  // control word bit positions
  localparam int CTL_HEAT_BIT = 0;
  localparam int CTL_CAL_BIT  = 1;
  localparam int CTL_CLR_BIT  = 2;
  // status word bit positions
  localparam int STS_CAL_ACT = 0;
  localparam int STS_CAL_BLK = 1;
  localparam int STS_ALARM   = 2;
  localparam int STS_REG_ACT = 3;

  // reset values and levels
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [15:0] MIN_SET_C   = 16'h0028;
  localparam logic [11:0] DAC_ZERO    = 12'h000;
  localparam logic [11:0] DAC_ZP300   = 12'h10e;
  localparam logic [11:0] DAC_ZP500   = 12'h0a4;
  localparam logic [11:0] DAC_MAX     = 12'hfff;
  localparam logic [2:0]  WR_BYTES    = 3'h4;
  localparam logic [2:0]  RD_BYTES    = 3'h6;

  // link states from the protocol engine
  localparam logic [1:0] LNK_INIT   = 2'h0;
  localparam logic [1:0] LNK_PREOP  = 2'h1;
  localparam logic [1:0] LNK_SAFEOP = 2'h2;
  localparam logic [1:0] LNK_OP     = 2'h3;

  // calibration sequence states
  typedef enum logic [4:0] {
    CAL_BOOT = 5'b00001,
    CAL_NONE = 5'b00010,
    CAL_RUN  = 5'b00100,
    CAL_OK   = 5'b01000,
    CAL_FAIL = 5'b10000
  } fpsi_cal_t;
endpackage

// [fpsi_pwm.sv]
`timescale 1ns/1ns
module fpsi_pwm #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] duty_in,
  output logic              pwm_out
);
  if (W < 2 || W > 16) $error("pwm width out of range");

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pwm;
  } fpsi_pwm_t;

  fpsi_pwm_t s_ff, nxt_s;

  // free-running ramp compared with the power level
  always_comb begin
    nxt_s     = s_ff;
    nxt_s.cnt = s_ff.cnt + W'(1);
    nxt_s.pwm = s_ff.cnt < duty_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pwm_out = s_ff.pwm;
endmodule

// [fpsi_top.sv]
`timescale 1ns/1ns
module fpsi_top #(
  parameter int CYC_PER_MS   = fpsi_pkg::CYC_PER_MS,
  parameter int BOOT_CAL_MS  = fpsi_pkg::BOOT_CAL_MS,
  parameter int BOOT_ALM_MS  = fpsi_pkg::BOOT_ALM_MS,
  parameter int CAL_BLOCK_MS = fpsi_pkg::CAL_BLOCK_MS,
  parameter int PWM_W        = 8
) (
  // clock and reset
  input  wire logic             MCLK_IN,
  input  wire logic             RST_IN,
  // byte stream from the fieldbus master
  input  wire logic             XFER_START_IN,
  input  wire logic             WR_STB_IN,
  input  wire logic [7:0]       WR_DATA_IN,
  input  wire logic             RD_STB_IN,
  output logic      [7:0]       RD_DATA_OUT,
  // control core status
  input  wire logic             CAL_DONE_OK_IN,
  input  wire logic             CAL_DONE_BAD_IN,
  input  wire logic             CAL_WRONG_IN,
  input  wire logic [15:0]      ERROR_CODE_IN,
  input  wire logic [15:0]      ACTUAL_TEMP_IN,
  input  wire logic [11:0]      ACTUAL_CODE_IN,
  input  wire logic [PWM_W-1:0] HEAT_POWER_IN,
  input  wire logic             RANGE_500_IN,
  // protocol engine status
  input  wire logic             LINK_ACTIVE_IN,
  input  wire logic [1:0]       LINK_STATE_IN,
  input  wire logic             LINK_CFG_ERR_IN,
  input  wire logic [1:0]       PORT_ACT_IN,
  // board pins
  input  wire logic [1:0]       PORT_LINK_IN,
  input  wire logic             UNDERVOLT_IN,
  input  wire logic             CFG_CHANGED_IN,
  // front panel
  output logic                  LED_CAL_OUT,
  output logic                  LED_HEAT_OUT,
  output logic                  LED_OUTPUT_OUT,
  output logic                  LED_ALARM_OUT,
  output logic                  LED_RUN_OUT,
  output logic                  LED_ERR_OUT,
  output logic      [1:0]       LED_LA_OUT,
  // flags and control core commands
  output logic                  CAL_ACTIVE_OUT,
  output logic                  CAL_BLOCKED_OUT,
  output logic                  ALARM_ACTIVE_OUT,
  output logic                  REG_ACTIVE_OUT,
  output logic      [15:0]      SETPOINT_OUT,
  output logic      [11:0]      ACTUAL_DAC_OUT
);
  if (CYC_PER_MS < 2) $error("CYC_PER_MS too small");
  if (CAL_BLOCK_MS >= 16383 || CAL_BLOCK_MS < BOOT_ALM_MS) $error("bad CAL_BLOCK_MS");
  if (BOOT_CAL_MS < 1 || BOOT_ALM_MS < BOOT_CAL_MS) $error("bad boot times");

  typedef struct packed {
    fpsi_pkg::fpsi_cal_t cal;
    logic [13:0] up_ms;
    logic        cfg_chg;
    logic [15:0] setpoint;
    logic [15:0] control;
    logic [23:0] wr_buf;
    logic [2:0]  wr_idx;
    logic [47:0] rd_snap;
    logic [2:0]  rd_idx;
    logic [7:0]  rd_data;
    logic        uv_s1, uv_s2;
    logic        cfg_s1, cfg_s2;
    logic [1:0]  lk_s1, lk_s2;
    logic [5:0]  act0, act1;
    logic        led_cal, led_heat, led_out, led_alarm, led_run, led_err;
    logic [1:0]  led_la;
    logic        cal_act, cal_blk, alarm, reg_act;
    logic [11:0] dac;
  } fpsi_top_t;

  fpsi_top_t s_ff, nxt_s;

  logic ms_tick;
  logic p_slow;
  logic p_fast;
  logic p_link;
  logic p_uv;
  logic p_flick;
  logic p_flash;
  logic p_imp;
  logic p_pwm;

  ////////////////////////////////////////////////////////////////////////////
  // pattern sources

  fpsi_blink_gen #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_blink (
    .clk_in      (MCLK_IN),
    .rst_in      (RST_IN),
    .ms_tick_out (ms_tick),
    .slow_out    (p_slow),
    .fast_out    (p_fast),
    .link_out    (p_link),
    .uv_out      (p_uv),
    .flick_out   (p_flick),
    .flash_out   (p_flash),
    .imp_out     (p_imp)
  );

  fpsi_pwm #(
    .W (PWM_W)
  ) u_pwm (
    .clk_in  (MCLK_IN),
    .rst_in  (RST_IN),
    .duty_in (HEAT_POWER_IN),
    .pwm_out (p_pwm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // activity stretch counter: reload on frame, count down each ms
  function automatic logic [5:0] act_next(input logic [5:0] c, input logic hit, input logic tick);
    if (hit) begin
      act_next = 6'(fpsi_pkg::ACT_HOLD_MS);
    end else if (tick && c != 6'h00) begin
      act_next = c - 6'h01;
    end else begin
      act_next = c;
    end
  endfunction

  // port LED: dark without link, flicker with traffic, else steady
  function automatic logic la_led(input logic lnk, input logic [5:0] c, input logic flick);
    la_led = lnk && ((c == 6'h00) || flick);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decoded conditions

  logic in_boot_cal;
  logic in_boot_alm;
  logic in_block;
  logic heat_req;
  logic cal_req;
  logic clr_req;
  logic err_any;
  logic cal_other_blk;
  logic cal_blocked;
  logic heat_ok;
  logic alarm_any;
  logic zero_out;
  logic [12:0] dac_sum;
  logic [11:0] zp_level;

  assign heat_req = s_ff.control[fpsi_pkg::CTL_HEAT_BIT];
  assign cal_req  = s_ff.control[fpsi_pkg::CTL_CAL_BIT];
  assign clr_req  = s_ff.control[fpsi_pkg::CTL_CLR_BIT];
  assign err_any  = ERROR_CODE_IN != 16'h0000;

  // power-on windows measured from reset release
  assign in_boot_cal = int'(s_ff.up_ms) < BOOT_CAL_MS;
  assign in_boot_alm = int'(s_ff.up_ms) < BOOT_ALM_MS;
  assign in_block    = int'(s_ff.up_ms) < CAL_BLOCK_MS;

  // calibration is refused while heating, clearing or faulted
  assign cal_other_blk = heat_req || clr_req || err_any || s_ff.uv_s2;
  assign cal_blocked   = in_block || cal_other_blk;

  // heating only when calibrated and everything allows it
  assign heat_ok = heat_req && (s_ff.cal == fpsi_pkg::CAL_OK) && !clr_req && !err_any &&
                   !s_ff.uv_s2 && (s_ff.setpoint >= fpsi_pkg::MIN_SET_C);

  assign alarm_any = (s_ff.cal == fpsi_pkg::CAL_FAIL) || CAL_WRONG_IN || err_any;

  // actual value forced to zero while calibrating or clearing
  assign zero_out = (s_ff.cal == fpsi_pkg::CAL_RUN) || clr_req;
  assign zp_level = RANGE_500_IN ? fpsi_pkg::DAC_ZP500 : fpsi_pkg::DAC_ZP300;
  assign dac_sum  = {1'b0, zp_level} + {1'b0, ACTUAL_CODE_IN};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_s = s_ff;

    // pin synchronisers
    nxt_s.uv_s1  = UNDERVOLT_IN;
    nxt_s.uv_s2  = s_ff.uv_s1;
    nxt_s.cfg_s1 = CFG_CHANGED_IN;
    nxt_s.cfg_s2 = s_ff.cfg_s1;
    nxt_s.lk_s1  = PORT_LINK_IN;
    nxt_s.lk_s2  = s_ff.lk_s1;

    // time since power-on, saturating at the blocking window
    if (ms_tick && in_block) begin
      nxt_s.up_ms = s_ff.up_ms + 14'h0001;
    end
    // configuration-changed strap caught once after release
    if (ms_tick && int'(s_ff.up_ms) == fpsi_pkg::CFG_CAP_MS) begin
      nxt_s.cfg_chg = s_ff.cfg_s2;
    end

    // byte writes: set point then control, low byte first
    if (XFER_START_IN) begin
      nxt_s.wr_idx  = 3'h0;
      nxt_s.rd_idx  = 3'h0;
      nxt_s.rd_snap = {ERROR_CODE_IN,
                       12'h000, s_ff.reg_act, s_ff.alarm, s_ff.cal_blk, s_ff.cal_act,
                       zero_out ? 16'h0000 : ACTUAL_TEMP_IN};
    end else begin
      if (WR_STB_IN && s_ff.wr_idx < fpsi_pkg::WR_BYTES) begin
        nxt_s.wr_idx = s_ff.wr_idx + 3'h1;
        unique case (s_ff.wr_idx)
          3'h0: nxt_s.wr_buf[7:0]   = WR_DATA_IN;
          3'h1: nxt_s.wr_buf[15:8]  = WR_DATA_IN;
          3'h2: nxt_s.wr_buf[23:16] = WR_DATA_IN;
          default: begin
            nxt_s.setpoint = s_ff.wr_buf[15:0];
            nxt_s.control  = {WR_DATA_IN, s_ff.wr_buf[23:16]};
          end
        endcase
      end
      // byte reads: actual, status, error, low byte first
      if (RD_STB_IN) begin
        if (s_ff.rd_idx < fpsi_pkg::RD_BYTES) begin
          nxt_s.rd_data = s_ff.rd_snap[8*s_ff.rd_idx +: 8];
          nxt_s.rd_idx  = s_ff.rd_idx + 3'h1;
        end else begin
          nxt_s.rd_data = 8'h00;
        end
      end
    end

    // calibration sequence
    unique case (s_ff.cal)
      fpsi_pkg::CAL_BOOT: begin
        if (!in_block) begin
          nxt_s.cal = fpsi_pkg::CAL_NONE;
        end
      end
      fpsi_pkg::CAL_RUN: begin
        if (CAL_DONE_OK_IN) begin
          nxt_s.cal = fpsi_pkg::CAL_OK;
        end else if (CAL_DONE_BAD_IN) begin
          nxt_s.cal = fpsi_pkg::CAL_FAIL;
        end
      end
      default: begin
        if (cal_req && !cal_blocked) begin
          nxt_s.cal = fpsi_pkg::CAL_RUN;
        end
      end
    endcase

    // flags to the master
    nxt_s.cal_act = s_ff.cal == fpsi_pkg::CAL_RUN;
    nxt_s.cal_blk = cal_blocked;
    nxt_s.alarm   = alarm_any;
    nxt_s.reg_act = heat_ok;

    // calibration LED: boot, undervoltage, running, clear, blocked
    if (in_boot_cal) begin
      nxt_s.led_cal = 1'b1;
    end else if (s_ff.uv_s2) begin
      nxt_s.led_cal = p_uv;
    end else if (s_ff.cal == fpsi_pkg::CAL_RUN) begin
      nxt_s.led_cal = 1'b1;
    end else if (clr_req) begin
      nxt_s.led_cal = p_slow;
    end else if (cal_req && cal_blocked) begin
      nxt_s.led_cal = p_fast;
    end else begin
      nxt_s.led_cal = 1'b0;
    end

    // alarm LED: boot notice on config change, bad cal, wrong cal, other error
    if (in_boot_alm && s_ff.cfg_chg) begin
      nxt_s.led_alarm = 1'b1;
    end else if (s_ff.cal == fpsi_pkg::CAL_FAIL) begin
      nxt_s.led_alarm = p_slow;
    end else if (CAL_WRONG_IN) begin
      nxt_s.led_alarm = p_fast;
    end else begin
      nxt_s.led_alarm = err_any;
    end

    // heat LED: steady while heating, fast when refused
    if (heat_ok) begin
      nxt_s.led_heat = 1'b1;
    end else begin
      nxt_s.led_heat = heat_req && p_fast;
    end

    // output LED: power brightness, idle measuring impulses
    if (heat_ok) begin
      nxt_s.led_out = p_pwm;
    end else if (!alarm_any && !clr_req && s_ff.cal != fpsi_pkg::CAL_BOOT) begin
      nxt_s.led_out = p_imp;
    end else begin
      nxt_s.led_out = 1'b0;
    end

    // link run and error LEDs
    if (!LINK_ACTIVE_IN) begin
      nxt_s.led_run = 1'b0;
      nxt_s.led_err = 1'b0;
    end else begin
      unique case (LINK_STATE_IN)
        fpsi_pkg::LNK_INIT:   nxt_s.led_run = 1'b0;
        fpsi_pkg::LNK_PREOP:  nxt_s.led_run = p_link;
        fpsi_pkg::LNK_SAFEOP: nxt_s.led_run = p_flash;
        default:              nxt_s.led_run = 1'b1;
      endcase
      nxt_s.led_err = LINK_CFG_ERR_IN && p_link;
    end

    // port link/activity LEDs
    nxt_s.act0      = act_next(s_ff.act0, PORT_ACT_IN[0], ms_tick);
    nxt_s.act1      = act_next(s_ff.act1, PORT_ACT_IN[1], ms_tick);
    nxt_s.led_la[0] = la_led(s_ff.lk_s2[0], s_ff.act0, p_flick);
    nxt_s.led_la[1] = la_led(s_ff.lk_s2[1], s_ff.act1, p_flick);

    // actual value output level
    if (zero_out || s_ff.cal != fpsi_pkg::CAL_OK) begin
      nxt_s.dac = fpsi_pkg::DAC_ZERO;
    end else if (dac_sum[12]) begin
      nxt_s.dac = fpsi_pkg::DAC_MAX;
    end else begin
      nxt_s.dac = dac_sum[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      s_ff          <= '0;
      s_ff.cal      <= fpsi_pkg::CAL_BOOT;
      s_ff.setpoint <= fpsi_pkg::WORD_RST;
      s_ff.control  <= fpsi_pkg::WORD_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign RD_DATA_OUT      = s_ff.rd_data;
  assign LED_CAL_OUT      = s_ff.led_cal;
  assign LED_HEAT_OUT     = s_ff.led_heat;
  assign LED_OUTPUT_OUT   = s_ff.led_out;
  assign LED_ALARM_OUT    = s_ff.led_alarm;
  assign LED_RUN_OUT      = s_ff.led_run;
  assign LED_ERR_OUT      = s_ff.led_err;
  assign LED_LA_OUT       = s_ff.led_la;
  assign CAL_ACTIVE_OUT   = s_ff.cal_act;
  assign CAL_BLOCKED_OUT  = s_ff.cal_blk;
  assign ALARM_ACTIVE_OUT = s_ff.alarm;
  assign REG_ACTIVE_OUT   = s_ff.reg_act;
  assign SETPOINT_OUT     = s_ff.setpoint;
  assign ACTUAL_DAC_OUT   = s_ff.dac;
endmodule

// [tb.sv]
`timescale 1ns/1ns
module tb;
  // clock, reset and block pins
  logic MCLK_IN = 1'b0, RST_IN = 1'b1;
  logic XFER_START_IN, WR_STB_IN, RD_STB_IN, CAL_DONE_OK_IN, CAL_DONE_BAD_IN, CAL_WRONG_IN;
  logic RANGE_500_IN, LINK_ACTIVE_IN, LINK_CFG_ERR_IN, UNDERVOLT_IN, CFG_CHANGED_IN;
  logic [7:0]  WR_DATA_IN, RD_DATA_OUT, HEAT_POWER_IN;
  logic [15:0] ERROR_CODE_IN, ACTUAL_TEMP_IN, SETPOINT_OUT, act, sts;
  logic [11:0] ACTUAL_CODE_IN, ACTUAL_DAC_OUT;
  logic [1:0]  LINK_STATE_IN, PORT_ACT_IN, PORT_LINK_IN, LED_LA_OUT;
  logic LED_CAL_OUT, LED_HEAT_OUT, LED_OUTPUT_OUT, LED_ALARM_OUT, LED_RUN_OUT, LED_ERR_OUT;
  logic CAL_ACTIVE_OUT, CAL_BLOCKED_OUT, ALARM_ACTIVE_OUT, REG_ACTIVE_OUT;
  int bad_count = 0, check_count = 0;

  // 100 MHz clock
  always #5 MCLK_IN = ~MCLK_IN;

  // block with short counts, and the bus master
  fpsi_top #(.CYC_PER_MS(4), .BOOT_CAL_MS(3), .BOOT_ALM_MS(5), .CAL_BLOCK_MS(20)) u_dut (.*);
  fpsi_master u_mst (.clk_in(MCLK_IN), .xfer_out(XFER_START_IN), .wr_stb_out(WR_STB_IN),
    .wr_data_out(WR_DATA_IN), .rd_stb_out(RD_STB_IN), .rd_data_in(RD_DATA_OUT));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return LED_OUTPUT_OUT;
      1: return LED_HEAT_OUT;
      2: return LED_RUN_OUT;
      3: return LED_ERR_OUT;
      4: return LED_ALARM_OUT;
      6: return LED_LA_OUT[0];
      default: return LED_CAL_OUT;
    endcase
  endfunction

  task automatic ticks(input int n);
    repeat (n) @(negedge MCLK_IN);
  endtask

  // settle, then count rises and high cycles of one lamp
  task automatic meas(input int s, input int n, output int r, output int h);
    logic p, c;
    ticks(4);
    r = 0;
    h = 0;
    p = pick(s);
    repeat (n) begin
      @(negedge MCLK_IN);
      c = pick(s);
      r += int'(c && !p);
      h += int'(c);
      p = c;
    end
  endtask

  // bounded wait for calibration to run
  task automatic wait_cal(output int i);
    for (i = 0; i < 200 && CAL_ACTIVE_OUT !== 1'b1; i++) @(negedge MCLK_IN);
    if (i == 200) begin
      bad_count++;
      summarize();
    end
  endtask

  // power-on lamps and the blocked window
  task automatic t_boot();
    ticks(12);
    chk(LED_CAL_OUT, 1);
    chk(LED_ALARM_OUT, 1);
    chk({LED_RUN_OUT, LED_ERR_OUT}, 0);
    u_mst.send(16'h0000, 16'h0002);
    ticks(4);
    chk({CAL_BLOCKED_OUT, CAL_ACTIVE_OUT}, 2'b10);
  endtask

  // calibration runs once unblocked and ends well
  task automatic t_cal();
    int i;
    wait_cal(i);
    chk(i > 45, 1);
    chk({LED_CAL_OUT, CAL_BLOCKED_OUT}, 2'b10);
    chk(ACTUAL_DAC_OUT, 0);
    u_mst.fetch(act, sts);
    chk(act, 0);
    chk(sts, 16'h0001 << fpsi_pkg::STS_CAL_ACT);
    u_mst.send(16'h0000, 16'h0000);
    @(negedge MCLK_IN) CAL_DONE_OK_IN = 1'b1;
    @(negedge MCLK_IN) CAL_DONE_OK_IN = 1'b0;
    ticks(2);
    chk(ACTUAL_DAC_OUT, fpsi_pkg::DAC_ZP300 + 12'h005);
    RANGE_500_IN = 1'b1;
    ticks(3);
    chk(ACTUAL_DAC_OUT, fpsi_pkg::DAC_ZP500 + 12'h005);
    RANGE_500_IN = 1'b0;
  endtask

  // idle impulses, heating, brightness and blocked heat
  task automatic t_heat();
    int r, h;
    meas(0, 4800, r, h);
    chk(r, 1);
    u_mst.send(16'h0064, 16'h0001);
    ticks(4);
    chk({REG_ACTIVE_OUT, LED_HEAT_OUT}, 2'b11);
    chk(SETPOINT_OUT, 16'h0064);
    u_mst.fetch(act, sts);
    chk(act, 16'h0123);
    chk(sts, (16'h0001 << fpsi_pkg::STS_REG_ACT) | (16'h0001 << fpsi_pkg::STS_CAL_BLK));
    meas(0, 2560, r, h);
    chk(h > 500 && h < 780, 1);
    u_mst.send(16'h0014, 16'h0001);
    ticks(4);
    chk(REG_ACTIVE_OUT, 0);
    meas(1, 4000, r, h);
    chk(r, 4);
    u_mst.send(16'h0000, 16'h0000);
  endtask

  // link state lamps and port lamps
  task automatic t_link();
    int r, h;
    LINK_ACTIVE_IN = 1'b1;
    LINK_STATE_IN = fpsi_pkg::LNK_PREOP;
    meas(2, 3200, r, h);
    chk(r, 2);
    LINK_CFG_ERR_IN = 1'b1;
    meas(3, 3200, r, h);
    chk(r, 2);
    LINK_STATE_IN = fpsi_pkg::LNK_SAFEOP;
    meas(2, 4800, r, h);
    chk(r, 1);
    PORT_LINK_IN = 2'b01;
    ticks(5);
    chk(LED_LA_OUT, 2'b01);
    // one frame on port 0 makes its lamp flicker for the hold time
    PORT_ACT_IN = 2'b01;
    @(negedge MCLK_IN) PORT_ACT_IN = 2'b00;
    meas(6, 160, r, h);
    chk(h < 120, 1);
  endtask

  // failed calibration, fault clear, undervoltage
  task automatic t_fail();
    int r, h;
    u_mst.send(16'h0000, 16'h0002);
    wait_cal(r);
    u_mst.send(16'h0000, 16'h0000);
    @(negedge MCLK_IN) CAL_DONE_BAD_IN = 1'b1;
    @(negedge MCLK_IN) CAL_DONE_BAD_IN = 1'b0;
    ticks(2);
    chk(ALARM_ACTIVE_OUT, 1);
    meas(4, 4000, r, h);
    chk(r, 1);
    u_mst.send(16'h0000, 16'h0004);
    meas(5, 4000, r, h);
    chk(r, 1);
    u_mst.send(16'h0000, 16'h0000);
    UNDERVOLT_IN = 1'b1;
    meas(5, 4000, r, h);
    chk(r, 2);
  endtask

  // reset, then the scenarios in order
  initial begin
    {CAL_DONE_OK_IN, CAL_DONE_BAD_IN, CAL_WRONG_IN, RANGE_500_IN} = 4'h0;
    {LINK_ACTIVE_IN, LINK_CFG_ERR_IN, UNDERVOLT_IN, CFG_CHANGED_IN} = 4'h1;
    {ERROR_CODE_IN, ACTUAL_TEMP_IN, HEAT_POWER_IN, ACTUAL_CODE_IN} = {32'h0000_0123, 8'h40, 12'h005};
    {LINK_STATE_IN, PORT_ACT_IN, PORT_LINK_IN} = 6'h00;
    ticks(20);
    RST_IN = 1'b0;
    t_boot();
    t_cal();
    t_heat();
    t_link();
    t_fail();
    summarize();
  end
endmodule
